/* shared/e1t_pkg.sv */
// Constants and state types shared by the E1 frame-timing block.
// Assumes one 125 MHz system clock that oversamples both link clocks.
package e1t_pkg;

    // Positions within a 256-bit E1 frame, written as timeslot * 8 + bit.
    localparam logic [7:0] LAST_POS = 8'hff;
    localparam logic [7:0] FAS_LAST_POS = 8'h07;
    localparam logic [7:0] MF_CHECK_POS = 8'h83;
    localparam logic [4:0] SIG_SLOT = 5'h10;
    localparam logic [4:0] FAS_SLOT = 5'h00;
    localparam logic [3:0] LAST_FRAME = 4'hf;
    localparam logic [3:0] FIRST_FRAME = 4'h0;

    // Fixed codes of the line format.
    localparam logic [7:0] IDLE_CODE = 8'hd5;
    localparam logic [6:0] FAS_WORD = 7'h1b;
    localparam logic [3:0] MFAS_NIBBLE = 4'h0;

    // Field positions of the transmit extra-bits register.
    localparam int XB_ONE_BIT = 3;
    localparam int DMA_BIT = 2;
    localparam int XB_TWO_BIT = 1;
    localparam int XB_THREE_BIT = 0;

    // Field positions of the transmit and common control registers.
    localparam int TXC_XSRC_BIT = 2;
    localparam int TXC_CCS_BIT = 5;
    localparam int CCR_HDB3_BIT = 0;
    localparam int CCR_APAR_BIT = 6;

    // Lanes of the sampled link bundle.
    localparam int LANE_W = 4;
    localparam int LN_SER = 0;
    localparam int LN_FS = 1;
    localparam int LN_MS = 2;
    localparam int LN_XD = 3;
    localparam int LN_POS = 0;
    localparam int LN_NEG = 1;

    // Link-bit delays through each direction.
    localparam int TX_DELAY = 5;
    localparam int RX_DEC_DEPTH = 6;

    typedef enum logic {
        RX_HUNT = 1'b0,
        RX_LOCKED = 1'b1
    } e1t_rx_state_t;

    typedef struct packed {
        logic [LANE_W-1:0] s1;
        logic [LANE_W-1:0] s2;
        logic clkS1;
        logic clkS2;
        logic clkPrev;
        logic rise;
        logic [LANE_W-1:0] data;
    } e1t_smp_st_t;

    typedef struct packed {
        logic [7:0] pos;
        logic [3:0] frame;
        logic prevFs;
        logic prevMs;
        logic [TX_DELAY-1:0] dly;
        logic pol;
        logic linePos;
        logic lineNeg;
        logic mfMark;
        logic afMark;
        logic [7:0] xbRead;
    } e1t_tx_st_t;

    typedef struct packed {
        e1t_rx_state_t state;
        logic lastPol;
        logic [RX_DEC_DEPTH-1:0] dec;
        logic [7:0] hist;
        logic [7:0] pos;
        logic [3:0] frame;
        logic fasFrame;
        logic mfOnNonAlign;
        logic [31:0][3:0] sig;
        logic serial;
        logic sd;
        logic fs;
        logic ms;
        logic cs;
        logic af;
    } e1t_rx_st_t;

endpackage

/* shared/e1t_lane_if.sv */
// Bundle of link signals after sampling into the system clock domain.
// Assumes the source is an e1t_link_sampler on the same clock.
`timescale 1ns/100ps
interface e1t_lane_if;
    import e1t_pkg::*;
    logic rise;
    logic [LANE_W-1:0] data;
    modport src (output rise, output data);
    modport dst (input rise, input data);
endinterface

/* rtl/e1t_link_sampler.sv */
// Two-flop synchroniser for one link clock and its data lanes, with edge detect.
// Assumes the link clock is much slower than clk, so each level lasts several cycles.
`timescale 1ns/100ps
module e1t_link_sampler (
    input wire logic clk,
    input wire logic rst,
    input wire logic linkClock,
    input wire logic [e1t_pkg::LANE_W-1:0] linkData,
    e1t_lane_if.src lane
);
    import e1t_pkg::*;

    e1t_smp_st_t st_ff;
    e1t_smp_st_t nxt_st;

    // Data is taken from the same synchroniser stage as the clock, so both stay aligned.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = linkData;
        nxt_st.s2 = st_ff.s1;
        nxt_st.clkS1 = linkClock;
        nxt_st.clkS2 = st_ff.clkS1;
        nxt_st.clkPrev = st_ff.clkS2;
        nxt_st.rise = st_ff.clkS2 & ~st_ff.clkPrev;
        nxt_st.data = st_ff.s2;
    end

    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign lane.rise = st_ff.rise;
    assign lane.data = st_ff.data;
endmodule

/* rtl/e1t_rx_deframer.sv */
// Receive side: HDB3 decode, frame and multiframe timing, signaling extraction.
// Assumes a lane bundle of pos/neg line bits sampled once per receive bit.
`timescale 1ns/100ps
module e1t_rx_deframer (
    input wire logic clk,
    input wire logic rst,
    e1t_lane_if.dst lane,
    input wire logic hdb3En,
    output logic rxSerialOut,
    output logic rxSignalingOut,
    output logic rxFrameSyncOut,
    output logic rxMultiframeSyncOut,
    output logic rxCrcMultiframeSyncOut,
    output logic rxAlignFrameMarker
);
    import e1t_pkg::*;

    e1t_rx_st_t st_ff;
    e1t_rx_st_t nxt_st;
    logic mark;
    logic viol;
    logic [7:0] posNow;
    logic [3:0] frameNow;
    logic [3:0] crcFrame;
    logic [4:0] tsNow;
    logic [4:0] lowSlot;
    logic [3:0] nib;

    // Timing follows the bit leaving the decoder, so markers and data line up.
    always_comb begin
        nxt_st = st_ff;
        mark = lane.data[LN_POS] | lane.data[LN_NEG];
        viol = hdb3En & mark & (lane.data[LN_POS] == st_ff.lastPol);
        posNow = st_ff.pos + 8'h01;
        frameNow = st_ff.frame;
        tsNow = posNow[7:3];
        lowSlot = 5'h00;
        nib = 4'h0;
        crcFrame = st_ff.frame;
        if (lane.rise) begin
            if (mark) begin
                nxt_st.lastPol = lane.data[LN_POS];
            end
            nxt_st.dec = {st_ff.dec[RX_DEC_DEPTH-2:0], mark & ~viol};
            if (viol) begin
                nxt_st.dec[3] = 1'b0; // Substituted B pulse removed. [R19]
            end
            nxt_st.serial = st_ff.dec[RX_DEC_DEPTH-1]; // Sixth bit period. [R19]
            nxt_st.hist = {st_ff.hist[6:0], st_ff.dec[RX_DEC_DEPTH-1]};
            if (st_ff.state == RX_HUNT && nxt_st.hist[6:0] == FAS_WORD) begin
                posNow = FAS_LAST_POS;
                nxt_st.state = RX_LOCKED;
                nxt_st.fasFrame = 1'b1;
            end else if (posNow == 8'h00) begin
                frameNow = st_ff.frame + 4'h1;
                nxt_st.fasFrame = ~st_ff.fasFrame; // Flips on true boundaries. [R21]
            end
            tsNow = posNow[7:3];
            // Either frame parity may open the CAS multiframe. [R22]
            if (st_ff.state == RX_LOCKED && posNow == MF_CHECK_POS &&
                    nxt_st.hist[3:0] == MFAS_NIBBLE) begin
                frameNow = FIRST_FRAME;
                nxt_st.mfOnNonAlign = ~nxt_st.fasFrame;
            end
            if (tsNow == SIG_SLOT && posNow[2:0] == 3'h7 && frameNow != FIRST_FRAME) begin
                nxt_st.sig[{1'b0, frameNow}] = nxt_st.hist[7:4];
                nxt_st.sig[{1'b1, frameNow}] = nxt_st.hist[3:0];
            end
            // The CRC4 multiframe always begins on an alignment frame. [R22]
            crcFrame = frameNow - {3'h0, nxt_st.mfOnNonAlign};
            nxt_st.pos = posNow;
            nxt_st.frame = frameNow;
            nxt_st.fs = (posNow == LAST_POS); // One bit early. [R20]
            nxt_st.ms = (posNow == LAST_POS) && frameNow == LAST_FRAME; // [R21]
            nxt_st.cs = (posNow == LAST_POS) && crcFrame == LAST_FRAME; // [R21]
            nxt_st.af = nxt_st.fasFrame;
            // Signaling nibble in bits 5 to 8 of the chosen slots only. [R16] [R17] [R18]
            lowSlot = (frameNow == FIRST_FRAME) ? 5'h0f : {1'b0, frameNow - 4'h1};
            if (tsNow == lowSlot && frameNow != 4'h1) begin
                nib = st_ff.sig[(frameNow == FIRST_FRAME) ? 5'h0f : {1'b0, frameNow}];
            end else if (tsNow == {1'b1, frameNow} && frameNow != FIRST_FRAME) begin
                nib = st_ff.sig[{1'b1, frameNow}];
            end
            nxt_st.sd = posNow[2] & nib[~posNow[1:0]];
        end
    end

    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rxSerialOut = st_ff.serial;
    assign rxSignalingOut = st_ff.sd;
    assign rxFrameSyncOut = st_ff.fs;
    assign rxMultiframeSyncOut = st_ff.ms;
    assign rxCrcMultiframeSyncOut = st_ff.cs;
    assign rxAlignFrameMarker = st_ff.af;

    property p_rx_serial;
        @(posedge clk) disable iff (rst)
        lane.rise |=> rxSerialOut == $past(st_ff.dec[RX_DEC_DEPTH-1]);
    endproperty
    a_rx_serial: assert property (p_rx_serial) else $error("rx serial not decoder tail"); // [R19]

    property p_rx_fsync;
        @(posedge clk) disable iff (rst)
        rxFrameSyncOut |-> st_ff.pos == LAST_POS;
    endproperty
    a_rx_fsync: assert property (p_rx_fsync) else $error("rx frame sync off boundary"); // [R20]

    property p_rx_mf_low;
        @(posedge clk) disable iff (rst)
        $fell(rxFrameSyncOut) |-> !rxMultiframeSyncOut && !rxCrcMultiframeSyncOut;
    endproperty
    a_rx_mf_low: assert property (p_rx_mf_low) else $error("mf sync outlived frame sync"); // [R21]

    property p_rx_sd_quiet;
        @(posedge clk) disable iff (rst)
        (st_ff.pos[7:3] == FAS_SLOT || st_ff.pos[7:3] == SIG_SLOT || !st_ff.pos[2])
            |-> !rxSignalingOut;
    endproperty
    a_rx_sd_quiet: assert property (p_rx_sd_quiet) else $error("signaling out of place"); // [R18]
endmodule

/* rtl/e1t_framer.sv */
// E1 frame-timing block: transmit timeslot-16 and idle insertion, receive timing.
// Assumes both link clocks are far slower than clk and register values are held steady.
//
// Operation
// R1: CAS mode fills timeslot 16 of frame 0 with alignment, extra and alarm bits.
// R2: Extra bits come from the register when selected, else sampled from the input.
// R3: CCS mode passes every timeslot 16 bit straight from serial input.
// R4: Software writes zero to reserved upper extra-bit register bits, ignores them on read.
// R5: Each set idle-select bit forces its timeslot to code 11010101 on the line.
// R6: Idle bits map one per timeslot, first register bit 0 to fourth bit 7.
// R7: Idle bits of timeslots 0 and 16 have no effect.
// R8: Multiframe sync rising edge sets multiframe alignment, shown on the multiframe marker.
// R9: Frame sync rising edge sets frame position, shown on the align-frame marker.
// R10: With sync inputs low the block runs a free alignment of its own.
// R11: Align-frame marker flags even frames, or odd frames when parity bit is set.
// R12: The driver raises sync inputs one transmit bit before the true boundary.
// R13: The multiframe marker responds to the rising edge of either sync input; the code acts on the multiframe sync edge only.
// R14: The align-frame marker changes exactly on true frame boundaries.
// R15: Serial input reaches the line outputs five transmit bit periods later.
// R16: Receive signaling appears in slots 15, 17, then n-1 and n+16.
// R17: Signaling nibble A to D sits in bits 5 to 8 of each slot.
// R18: Receive signaling is never valid in timeslots 0 and 16.
// R19: Received data leaves serially six bits later, HDB3-decoded when enabled.
// R20: Receive frame and multiframe syncs rise one bit before the boundary.
// R21: Receive align marker flips on boundaries; multiframe syncs fall with frame sync.
// R22: CAS multiframe may start on either frame; CRC4 starts on an align frame.
// R23: The alarm register bit sets or clears bit 6 of timeslot 16, frame 0.
`timescale 1ns/100ps
module e1t_framer (
    input wire logic clk,
    input wire logic rst,
    input wire logic txClock,
    input wire logic txSerialIn,
    input wire logic txFrameSyncIn,
    input wire logic txMultiframeSyncIn,
    input wire logic txExtraIn,
    input wire logic [7:0] txExtraBitsReg,
    input wire logic [7:0] idleSelectRegA,
    input wire logic [7:0] idleSelectRegB,
    input wire logic [7:0] idleSelectRegC,
    input wire logic [7:0] idleSelectRegD,
    input wire logic [7:0] txControlReg,
    input wire logic [7:0] commonControlReg,
    output logic [7:0] txExtraBitsRead,
    output logic txLinePos,
    output logic txLineNeg,
    output logic txMultiframeMarker,
    output logic txAlignFrameMarker,
    input wire logic rxClock,
    input wire logic rxLinePos,
    input wire logic rxLineNeg,
    output logic rxSerialOut,
    output logic rxSignalingOut,
    output logic rxFrameSyncOut,
    output logic rxMultiframeSyncOut,
    output logic rxCrcMultiframeSyncOut,
    output logic rxAlignFrameMarker
);
    import e1t_pkg::*;

    e1t_lane_if txLane ();
    e1t_lane_if rxLane ();

    e1t_tx_st_t st_ff;
    e1t_tx_st_t nxt_st;
    logic [31:0] idleVec;
    logic fsEdge;
    logic msEdge;
    logic [7:0] posNow;
    logic [3:0] frameNow;
    logic [4:0] tsNow;
    logic [2:0] bitNow;
    logic extraSrc;
    logic ccsMode;
    logic alignPar;
    logic dataNow;
    logic xOne;
    logic xTwo;
    logic xThree;

    // Both link clocks and their pins are brought into the clk domain first.
    e1t_link_sampler u_tx_smp (
        .clk(clk),
        .rst(rst),
        .linkClock(txClock),
        .linkData({txExtraIn, txMultiframeSyncIn, txFrameSyncIn, txSerialIn}),
        .lane(txLane.src)
    );

    e1t_link_sampler u_rx_smp (
        .clk(clk),
        .rst(rst),
        .linkClock(rxClock),
        .linkData({2'b00, rxLineNeg, rxLinePos}),
        .lane(rxLane.src)
    );

    e1t_rx_deframer u_rx (
        .clk(clk),
        .rst(rst),
        .lane(rxLane.dst),
        .hdb3En(commonControlReg[CCR_HDB3_BIT]),
        .rxSerialOut(rxSerialOut),
        .rxSignalingOut(rxSignalingOut),
        .rxFrameSyncOut(rxFrameSyncOut),
        .rxMultiframeSyncOut(rxMultiframeSyncOut),
        .rxCrcMultiframeSyncOut(rxCrcMultiframeSyncOut),
        .rxAlignFrameMarker(rxAlignFrameMarker)
    );

    // Control fields and the idle map, one bit per timeslot. [R6]
    assign idleVec = {idleSelectRegD, idleSelectRegC, idleSelectRegB, idleSelectRegA};
    assign extraSrc = txControlReg[TXC_XSRC_BIT];
    assign ccsMode = txControlReg[TXC_CCS_BIT];
    assign alignPar = commonControlReg[CCR_APAR_BIT];

    // Extra bits from the register or from the extra-bit pin in its bit time. [R2]
    assign xOne = extraSrc ? txExtraBitsReg[XB_ONE_BIT] : txLane.data[LN_XD];
    assign xTwo = extraSrc ? txExtraBitsReg[XB_TWO_BIT] : txLane.data[LN_XD];
    assign xThree = extraSrc ? txExtraBitsReg[XB_THREE_BIT] : txLane.data[LN_XD];

    // The position counter tracks the bit sampled at the serial input. A sync edge
    // marks the last bit of a frame, because the driver raises it one bit early;
    // with both syncs held low the counters simply run free.
    always_comb begin
        nxt_st = st_ff;
        fsEdge = txLane.data[LN_FS] & ~st_ff.prevFs;
        msEdge = txLane.data[LN_MS] & ~st_ff.prevMs;
        posNow = (fsEdge | msEdge) ? LAST_POS : st_ff.pos + 8'h01; // [R9] [R12]
        if (msEdge) begin
            frameNow = LAST_FRAME; // [R8] [R12]
        end else if (posNow == 8'h00) begin
            frameNow = st_ff.frame + 4'h1; // [R10]
        end else begin
            frameNow = st_ff.frame;
        end
        tsNow = posNow[7:3];
        bitNow = posNow[2:0];
        dataNow = txLane.data[LN_SER];
        if (!ccsMode && frameNow == FIRST_FRAME && tsNow == SIG_SLOT) begin
            // Multiframe word 0000, then X, alarm, X, X. [R1]
            unique case (bitNow)
                3'h4: dataNow = xOne;
                3'h5: dataNow = txExtraBitsReg[DMA_BIT]; // [R23]
                3'h6: dataNow = xTwo;
                3'h7: dataNow = xThree;
                default: dataNow = 1'b0;
            endcase
        end else if (tsNow != FAS_SLOT && tsNow != SIG_SLOT && idleVec[tsNow]) begin
            dataNow = IDLE_CODE[~bitNow]; // [R5] [R7]
        end
        if (txLane.rise) begin
            nxt_st.prevFs = txLane.data[LN_FS];
            nxt_st.prevMs = txLane.data[LN_MS];
            nxt_st.pos = posNow;
            nxt_st.frame = frameNow;
            // Five stages plus the line flop give the fixed delay. [R15]
            nxt_st.dly = {st_ff.dly[TX_DELAY-2:0], dataNow};
            nxt_st.linePos = st_ff.dly[TX_DELAY-1] & ~st_ff.pol;
            nxt_st.lineNeg = st_ff.dly[TX_DELAY-1] & st_ff.pol;
            nxt_st.pol = st_ff.pol ^ st_ff.dly[TX_DELAY-1];
            nxt_st.mfMark = frameNow == FIRST_FRAME ||
                (frameNow == LAST_FRAME && posNow == LAST_POS); // [R8] [R13]
            // Only a true boundary may move the marker, so a sync edge that
            // renumbers the frame one bit early cannot flip it early. [R11] [R14]
            if (posNow == 8'h00) begin
                nxt_st.afMark = alignPar ? frameNow[0] : ~frameNow[0];
            end
        end
        // Reserved bits read back as written; software must not rely on them. [R4]
        nxt_st.xbRead = txExtraBitsReg;
    end

    // State register; the line starts idle with no pulses.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign txLinePos = st_ff.linePos;
    assign txLineNeg = st_ff.lineNeg;
    assign txMultiframeMarker = st_ff.mfMark;
    assign txAlignFrameMarker = st_ff.afMark;
    assign txExtraBitsRead = st_ff.xbRead;

    property p_mfas_zero;
        @(posedge clk) disable iff (rst)
        txLane.rise && !ccsMode && frameNow == FIRST_FRAME && posNow[7:2] == 6'h20
            |=> st_ff.dly[0] == 1'b0;
    endproperty
    a_mfas_zero: assert property (p_mfas_zero) else $error("alignment word not zero"); // [R1]

    property p_xbit_reg;
        @(posedge clk) disable iff (rst)
        txLane.rise && !ccsMode && extraSrc && frameNow == FIRST_FRAME && posNow == 8'h84
            |=> st_ff.dly[0] == $past(txExtraBitsReg[XB_ONE_BIT]);
    endproperty
    a_xbit_reg: assert property (p_xbit_reg) else $error("extra bit one not from register"); // [R2]

    property p_alarm;
        @(posedge clk) disable iff (rst)
        txLane.rise && !ccsMode && frameNow == FIRST_FRAME && posNow == 8'h85
            |=> st_ff.dly[0] == $past(txExtraBitsReg[DMA_BIT]);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm bit wrong"); // [R23]

    property p_ccs_pass;
        @(posedge clk) disable iff (rst)
        txLane.rise && ccsMode && tsNow == SIG_SLOT |=> st_ff.dly[0] == $past(txLane.data[LN_SER]);
    endproperty
    a_ccs_pass: assert property (p_ccs_pass) else $error("ccs slot 16 altered"); // [R3]

    property p_idle;
        @(posedge clk) disable iff (rst)
        txLane.rise && tsNow != FAS_SLOT && tsNow != SIG_SLOT && idleVec[tsNow]
            |=> st_ff.dly[0] == IDLE_CODE[~$past(bitNow)];
    endproperty
    a_idle: assert property (p_idle) else $error("idle code not inserted"); // [R5]

    property p_ts0_free;
        @(posedge clk) disable iff (rst)
        txLane.rise && tsNow == FAS_SLOT |=> st_ff.dly[0] == $past(txLane.data[LN_SER]);
    endproperty
    a_ts0_free: assert property (p_ts0_free) else $error("timeslot 0 altered"); // [R7]

    property p_line_delay;
        @(posedge clk) disable iff (rst)
        txLane.rise |=> (txLinePos | txLineNeg) == $past(st_ff.dly[TX_DELAY-1]);
    endproperty
    a_line_delay: assert property (p_line_delay) else $error("line delay broken"); // [R15]

    property p_mf_edge;
        @(posedge clk) disable iff (rst)
        txLane.rise && msEdge |=> txMultiframeMarker && st_ff.pos == LAST_POS;
    endproperty
    a_mf_edge: assert property (p_mf_edge) else $error("mf marker missed edge"); // [R13]

    property p_af_boundary;
        @(posedge clk) disable iff (rst)
        $changed(txAlignFrameMarker) |-> st_ff.pos == 8'h00;
    endproperty
    a_af_boundary: assert property (p_af_boundary) else $error("align marker off boundary"); // [R14]
endmodule

/* verif/e1t_link_model.sv */
// Far-side model: line interface clock plus the backplane serial stream and syncs.
// Assumes the bench reads pos and frame to reckon what the line must carry.
`timescale 1ns/100ps
module e1t_link_model (
    output logic linkClk,
    output logic ser,
    output logic fs,
    output logic ms,
    output logic xd,
    output logic [7:0] pos,
    output logic [3:0] frame
);
    // Data moves on the falling link edge, so each bit is steady at the rise.
    // The clock starts late and off phase, well after the block leaves reset.
    initial begin
        {linkClk, ser, fs, ms, xd} = 5'h00;
        {frame, pos} = 12'hff9;
        #213;
        forever begin
            #40 linkClk = 1'b1;
            #40 linkClk = 1'b0;
            {frame, pos} = {frame, pos} + 12'h001;
            ser = pos[0] ^ pos[3] ^ pos[6] ^ frame[1];
            xd = pos[1] ^ frame[0];
            fs = pos == 8'hff;
            ms = fs && frame == 4'hf;
        end
    end
endmodule

/* verif/test_e1t_framer.sv */
// Bench for the framer: loops the line back into the receiver and checks both ways.
// Assumes the link model supplies the link clock, the serial stream and the syncs.
`timescale 1ns/100ps
module test_e1t_framer;
    import e1t_pkg::*;
    logic clk, rst, linkClk, ser, fs, ms, xd, linePos, lineNeg, mfMark, afMark, rxSer;
    logic [7:0] pos, xbReg, xbRead, idleA, idleB, idleC, idleD, txCtl, comCtl;
    logic [3:0] frame, k;
    logic [15:0] expLine, lineHist;
    logic expMf, expAf;
    int bitCnt, mfNum, cycles, failCount, checked;

    e1t_link_model i_link (.linkClk(linkClk), .ser(ser), .fs(fs), .ms(ms), .xd(xd),
        .pos(pos), .frame(frame));
    e1t_framer i_dut (.clk(clk), .rst(rst), .txClock(linkClk), .txSerialIn(ser),
        .txFrameSyncIn(fs), .txMultiframeSyncIn(ms), .txExtraIn(xd), .txExtraBitsReg(xbReg),
        .idleSelectRegA(idleA), .idleSelectRegB(idleB), .idleSelectRegC(idleC),
        .idleSelectRegD(idleD), .txControlReg(txCtl), .commonControlReg(comCtl),
        .txExtraBitsRead(xbRead), .txLinePos(linePos), .txLineNeg(lineNeg),
        .txMultiframeMarker(mfMark), .txAlignFrameMarker(afMark), .rxClock(linkClk),
        .rxLinePos(linePos), .rxLineNeg(lineNeg), .rxSerialOut(rxSer),
        .rxSignalingOut(), .rxFrameSyncOut(), .rxMultiframeSyncOut(),
        .rxCrcMultiframeSyncOut(), .rxAlignFrameMarker());

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failCount++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finalReport();
        if (failCount == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Registers are plain levels; readback lags one clock, so two are allowed.
    task automatic setCfg(input logic [7:0] xb, input logic [7:0] tc, input logic [7:0] cc);
        @(negedge clk);
        xbReg = xb;
        txCtl = tc;
        comCtl = cc;
        repeat (2) @(negedge clk);
        check("xbRead", xbRead, xb);
    endtask

    // Line bit that the block must send for one serial input bit.
    function automatic logic expBit(input logic [7:0] p, input logic [3:0] f, input logic s,
        input logic x);
        logic [7:0] word;
        logic [31:0] idle;
        word = {MFAS_NIBBLE, xbReg[3:0]};
        idle = {idleD, idleC, idleB, idleA};
        if (!txCtl[TXC_XSRC_BIT]) begin
            word = {MFAS_NIBBLE, x, xbReg[DMA_BIT], x, x};
        end
        if (p[7:3] == SIG_SLOT && f == 4'h0 && !txCtl[TXC_CCS_BIT]) begin
            return word[~p[2:0]];
        end
        if (idle[p[7:3]] && p[7:3] != SIG_SLOT && p[7:3] != 5'h00) begin
            return IDLE_CODE[~p[2:0]];
        end
        return s;
    endfunction

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Expectations are taken at the link rise, while the input bit is steady.
    always @(posedge linkClk) begin
        bitCnt <= bitCnt + 1;
        if (pos == 8'h00 && frame == 4'h0) begin
            mfNum <= mfNum + 1;
        end
        expLine[bitCnt[3:0]] <= expBit(pos, frame, ser, xd);
        expMf <= frame == 4'h0 || (frame == 4'hf && pos == 8'hff);
        if (pos == 8'h00) begin
            expAf <= frame[0] == comCtl[CCR_APAR_BIT];
        end
    end

    // Outputs settle four clocks after the rise, long before the link fall.
    always @(negedge linkClk) begin
        #1;
        k = bitCnt[3:0] - 4'h1;
        lineHist[k] = linePos | lineNeg;
        if (bitCnt > 24) begin
            check("txLine", linePos | lineNeg, expLine[k - 4'h5]);
            check("txMfMark", mfMark, expMf);
            check("txAfMark", afMark, expAf);
            check("rxSerial", rxSer, lineHist[k - 4'h7]);
        end
    end

    // Cut a hang short; the whole walk needs about 85000 cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            failCount++;
            finalReport();
        end
    end

    // Reset, then register source up to frame 8, pin source for one multiframe, and CCS up to frame 1.
    // Changes land at frame 8 so no idle or timeslot-16 bit is in flight.
    initial begin
        rst = 1'b1;
        {xbReg, txCtl, comCtl} = 24'h0d0401;
        {idleD, idleC, idleB, idleA} = 32'h40038003;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        setCfg(8'h0d, 8'h04, 8'h01);
        wait (mfNum == 1 && frame == 4'h8);
        setCfg(8'h09, 8'h00, 8'h41);
        wait (mfNum == 2 && frame == 4'h8);
        setCfg(8'h09, 8'h20, 8'h41);
        wait (mfNum == 3 && frame == 4'h1);
        finalReport();
    end
endmodule
